// ===== core/vmr_pkg.sv
// constants for the video mode register port
package vmr_pkg;
    localparam logic [3:0] OFS_MODE = 4'h3;
    localparam logic [3:0] OFS_CIDX = 4'h4;
    localparam logic [3:0] OFS_CDAT = 4'h5;
    localparam logic [3:0] OFS_DIDX = 4'h6;
    localparam logic [3:0] OFS_DDAT = 4'h7;
    localparam logic [3:0] OFS_COLOR = 4'h9;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] COLOR_RESET = 8'h8a;
    localparam logic [4:0] PTR_RESET = 5'h00;
    localparam logic [4:0] PASS_LO = 5'h0c;
    localparam logic [4:0] PASS_HI = 5'h11;
    localparam logic [3:0] WINDOW_INDEX = 4'h7;
    localparam int MB_TEXT80 = 0;
    localparam int MB_GFX = 1;
    localparam int MB_BW_BG = 2;
    localparam int MB_TXT_EN = 3;
    localparam int MB_HIRES = 4;
    localparam int MB_BLINK = 5;
    localparam int MB_WIN = 6;
    localparam int MB_BMP_EN = 7;
    localparam int CB_INTENS = 4;
    localparam int CB_BLUE = 5;
    localparam int CB_SYNC = 7;
    typedef enum logic [1:0] {VMR_JMP_MONO, VMR_JMP_COLOR, VMR_JMP_DUAL} vmr_jumper_t;
endpackage

// ===== core/vmr_top.sv
// host port register bank with controller write path and plane mixing
`timescale 1ns/1ps
module vmr_top
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // host i/o write port
    input wire logic io_wr,
    input wire logic io_mono_base,
    input wire logic [3:0] io_addr,
    input wire logic [7:0] io_wdata,
    // board straps
    input wire logic [1:0] emulation_select_jumper,
    input wire logic lut_program,
    // substitution table
    input wire logic [7:0] tbl_value [0:17],
    input wire logic [17:0] tbl_valid,
    // pixel inputs
    input wire logic [3:0] bmp_index,
    input wire logic txt_fg,
    input wire logic [3:0] txt_fg_color,
    input wire logic [3:0] txt_bg_color,
    input wire logic pixel_red_select,
    input wire logic pixel_green_select,
    // character controller write port
    output logic crtc_wr,
    output logic [4:0] crtc_addr,
    output logic [7:0] crtc_wdata,
    // control outputs
    output logic [7:0] mode_out,
    output logic [7:0] color_out,
    output logic emul_mono,
    output logic text80,
    output logic graphics,
    output logic bitmap_en,
    output logic text_video_en,
    output logic text_run,
    output logic [3:0] lut_index,
    output logic lut_index_valid,
    output logic [3:0] pix_out
);
    logic [7:0] video_mode_select;
    logic [7:0] palette_and_sync_select;
    logic [4:0] compat_ptr;
    logic [4:0] direct_ptr;
    logic started;
    logic [3:0] next_pix;
    logic [3:0] cga_pix;
    logic win_hit;

    // address decode helper used by every write path
    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        hit = (a == ofs);
    endfunction

    // substitution needed: listed register outside pass range with differing value
    function automatic logic subst(input logic [4:0] p, input logic [7:0] v,
                                   input logic [7:0] t, input logic ok);
        subst = ok && !(p >= vmr_pkg::PASS_LO && p <= vmr_pkg::PASS_HI) && (v != t);
    endfunction

    // pointers
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            compat_ptr <= vmr_pkg::PTR_RESET;
            direct_ptr <= vmr_pkg::PTR_RESET;
        end
        else if (io_wr && hit(io_addr, vmr_pkg::OFS_CIDX))
            compat_ptr <= io_wdata[4:0];
        else if (io_wr && hit(io_addr, vmr_pkg::OFS_DIDX))
            direct_ptr <= io_wdata[4:0];
    end

    // controller write port, one pulse per data write
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            crtc_wr <= 1'b0;
            crtc_addr <= vmr_pkg::PTR_RESET;
            crtc_wdata <= 8'h00;
        end
        else if (io_wr && hit(io_addr, vmr_pkg::OFS_CDAT))
        begin
            crtc_wr <= 1'b1;
            crtc_addr <= compat_ptr;
            // table index beyond 17 cannot be listed
            if (compat_ptr <= 5'h11 && subst(compat_ptr, io_wdata,
                    tbl_value[compat_ptr], tbl_valid[compat_ptr]))
                crtc_wdata <= tbl_value[compat_ptr];
            else
                crtc_wdata <= io_wdata;
        end
        else if (io_wr && hit(io_addr, vmr_pkg::OFS_DDAT))
        begin
            crtc_wr <= 1'b1;
            crtc_addr <= direct_ptr;
            crtc_wdata <= io_wdata;
        end
        else
            crtc_wr <= 1'b0;
    end

    // mode select and emulation choice
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            video_mode_select <= vmr_pkg::MODE_RESET;
            emul_mono <= 1'b0;
        end
        else
        begin
            if (io_wr && hit(io_addr, vmr_pkg::OFS_MODE))
            begin
                video_mode_select <= io_wdata;
                if (emulation_select_jumper == 2'(vmr_pkg::VMR_JMP_DUAL))
                    emul_mono <= io_mono_base;
            end
            if (emulation_select_jumper == 2'(vmr_pkg::VMR_JMP_MONO))
                emul_mono <= 1'b1;
            else if (emulation_select_jumper == 2'(vmr_pkg::VMR_JMP_COLOR))
                emul_mono <= 1'b0;
        end
    end

    // color select; reset holds default color and sync bit high
    always_ff @(posedge mclk)
    begin
        if (rst)
            palette_and_sync_select <= vmr_pkg::COLOR_RESET;
        else if (io_wr && hit(io_addr, vmr_pkg::OFS_COLOR))
            palette_and_sync_select <= io_wdata;
    end

    // sync start latch: once cleared the text controller keeps running
    always_ff @(posedge mclk)
    begin
        if (rst)
            started <= 1'b0;
        else if (!palette_and_sync_select[vmr_pkg::CB_SYNC])
            started <= 1'b1;
    end

    // decoded controls, registered for clean outputs
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            mode_out <= vmr_pkg::MODE_RESET;
            color_out <= vmr_pkg::COLOR_RESET;
            text80 <= 1'b0;
            graphics <= 1'b0;
            bitmap_en <= 1'b0;
            text_video_en <= 1'b0;
            text_run <= 1'b0;
            lut_index <= 4'h0;
            lut_index_valid <= 1'b0;
        end
        else
        begin
            mode_out <= video_mode_select;
            color_out <= palette_and_sync_select;
            text80 <= video_mode_select[vmr_pkg::MB_TEXT80];
            graphics <= video_mode_select[vmr_pkg::MB_GFX];
            bitmap_en <= video_mode_select[vmr_pkg::MB_BMP_EN];
            text_video_en <= video_mode_select[vmr_pkg::MB_TXT_EN];
            text_run <= started;
            lut_index <= palette_and_sync_select[3:0];
            // index only offered while the table loads, and then only with bitmap and window bits clear
            lut_index_valid <= lut_program && !video_mode_select[vmr_pkg::MB_BMP_EN]
                && !video_mode_select[vmr_pkg::MB_WIN];
        end
    end

    // compatible low-res palette: 00 background, else red/green plus blue plane
    always_comb
    begin
        if (!pixel_red_select && !pixel_green_select)
            cga_pix = palette_and_sync_select[3:0];
        else
            cga_pix = {palette_and_sync_select[vmr_pkg::CB_INTENS],
                       pixel_red_select, pixel_green_select,
                       palette_and_sync_select[vmr_pkg::CB_BLUE]};
    end

    assign win_hit = (bmp_index == vmr_pkg::WINDOW_INDEX);

    // pixel mixer; text memory is never touched here, only hidden
    always_comb
    begin
        next_pix = 4'h0;
        if (!started || !video_mode_select[vmr_pkg::MB_TXT_EN])
            next_pix = video_mode_select[vmr_pkg::MB_BMP_EN] ? bmp_index : 4'h0;
        else if (video_mode_select[vmr_pkg::MB_BMP_EN])
        begin
            if (video_mode_select[vmr_pkg::MB_WIN])
                next_pix = win_hit ? (txt_fg ? txt_fg_color : txt_bg_color) : bmp_index;
            else if (!video_mode_select[vmr_pkg::MB_BW_BG])
                next_pix = txt_fg ? txt_fg_color : bmp_index;
            else
                // text behind: bitmap wins unless it is background zero
                next_pix = (bmp_index != 4'h0) ? bmp_index
                    : (txt_fg ? txt_fg_color : 4'h0);
        end
        else if (video_mode_select[vmr_pkg::MB_GFX])
        begin
            if (video_mode_select[vmr_pkg::MB_HIRES])
                next_pix = pixel_green_select ? palette_and_sync_select[3:0] : 4'h0;
            else
                next_pix = cga_pix;
        end
        else if (emul_mono || video_mode_select[vmr_pkg::MB_BW_BG])
            next_pix = txt_fg ? palette_and_sync_select[3:0] : 4'h0;
        else if (video_mode_select[vmr_pkg::MB_BLINK])
            next_pix = txt_fg ? txt_fg_color : {1'b0, txt_bg_color[2:0]};
        else
            next_pix = txt_fg ? txt_fg_color : txt_bg_color;
    end

    // registered pixel output
    always_ff @(posedge mclk)
    begin
        if (rst)
            pix_out <= 4'h0;
        else
            pix_out <= next_pix;
    end
endmodule

// ===== sim/vmr_host.sv
// host model driving the i/o write port
`timescale 1ns/1ps
module vmr_host
(
    // clock
    input wire logic mclk,
    // i/o write port
    output logic io_wr,
    output logic io_mono_base,
    output logic [3:0] io_addr,
    output logic [7:0] io_wdata
);
    // quiet bus at time zero
    initial
    begin
        io_wr = 1'b0;
        io_mono_base = 1'b0;
        io_addr = 4'h0;
        io_wdata = 8'h00;
    end
    // one write, held from a falling edge across the taking edge
    task automatic wr(input logic mono, input logic [3:0] a, input logic [7:0] d);
        @(negedge mclk);
        io_wr = 1'b1;
        io_mono_base = mono;
        io_addr = a;
        io_wdata = d;
        @(posedge mclk);
    endtask
    // drop the strobe; lines invert so a stale value never looks held
    task automatic idle();
        @(negedge mclk);
        io_wr = 1'b0;
        io_addr = ~io_addr;
        io_wdata = ~io_wdata;
    endtask
    // controller sync: sync bit high for a while, then low
    task automatic sync_ctl(input int gap);
        wr(1'b0, vmr_pkg::OFS_COLOR, 8'h8a);
        idle();
        repeat (gap) @(negedge mclk);
        wr(1'b0, vmr_pkg::OFS_COLOR, 8'h0a);
        idle();
    endtask
endmodule

// ===== sim/vmr_chk.sv
// assertions on the video mode register port
`timescale 1ns/1ps
module vmr_chk
(
    // watched ports
    input wire logic mclk,
    input wire logic rst,
    input wire logic io_wr,
    input wire logic io_mono_base,
    input wire logic [3:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic [1:0] emulation_select_jumper,
    input wire logic crtc_wr,
    input wire logic [4:0] crtc_addr,
    input wire logic [7:0] crtc_wdata,
    input wire logic [7:0] mode_out,
    input wire logic emul_mono,
    input wire logic text_run
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // data writes on either port
    logic wr_dat;
    assign wr_dat = io_wr && (io_addr == vmr_pkg::OFS_CDAT || io_addr == vmr_pkg::OFS_DDAT);
    a_data_wr_pulse: assert property (wr_dat |=> crtc_wr)
        else $error("data write gave no strobe");
    a_strobe_cause: assert property (crtc_wr |-> $past(wr_dat))
        else $error("strobe without data write");
    a_direct_pass: assert property (io_wr && io_addr == vmr_pkg::OFS_DDAT
        |=> crtc_wdata == $past(io_wdata)) else $error("direct data altered");
    a_compat_ptr: assert property (io_wr && io_addr == vmr_pkg::OFS_CIDX
        ##1 io_wr && io_addr == vmr_pkg::OFS_CDAT
        |=> crtc_addr == $past(io_wdata[4:0], 2)) else $error("pointer not five bits");
    a_mode_copy: assert property (io_wr && io_addr == vmr_pkg::OFS_MODE
        |-> ##2 mode_out == $past(io_wdata, 2)) else $error("mode value lost");
    a_sync_start: assert property (io_wr && io_addr == vmr_pkg::OFS_COLOR && !io_wdata[7]
        |-> ##[1:3] text_run) else $error("text did not start");
    a_run_sticky: assert property (text_run |=> text_run)
        else $error("text run dropped");
    a_emul_mono: assert property (emulation_select_jumper == vmr_pkg::VMR_JMP_DUAL
        && io_wr && io_addr == vmr_pkg::OFS_MODE && io_mono_base |-> ##[1:3] emul_mono)
        else $error("mono base not emulated");
    // main scenarios reached
    cover property (crtc_wr);
    cover property (text_run);
    cover property (emul_mono);
endmodule
bind vmr_top vmr_chk u_chk (.mclk, .rst, .io_wr, .io_mono_base, .io_addr, .io_wdata,
    .emulation_select_jumper, .crtc_wr, .crtc_addr, .crtc_wdata, .mode_out, .emul_mono,
    .text_run);

// ===== sim/tb_video_mode_register_port.sv
// self-checking bench for the video mode register port
`timescale 1ns/1ps
module tb_video_mode_register_port;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic io_wr, io_mono_base, crtc_wr, emul_mono, text80, graphics, bitmap_en;
    logic text_video_en, text_run, lut_index_valid;
    logic [3:0] io_addr, lut_index, pix_out;
    logic [7:0] io_wdata, crtc_wdata, mode_out, color_out;
    logic [4:0] crtc_addr;
    logic [1:0] emulation_select_jumper = 2'h2;
    logic lut_program = 1'b0;
    logic [7:0] tbl_value [0:17];
    logic [17:0] tbl_valid = 18'h3fff7;
    logic [3:0] bmp_index = 4'h0, txt_fg_color = 4'h3, txt_bg_color = 4'h1;
    logic txt_fg = 1'b0, pixel_red_select = 1'b0, pixel_green_select = 1'b0;
    int miscompares = 0;
    int check_count = 0;
    always #25 mclk = ~mclk;
    vmr_top uut (.*);
    vmr_host h (.mclk, .io_wr, .io_mono_base, .io_addr, .io_wdata);
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // index then data, wait for the strobe under a bound
    task automatic ctl_case(input logic [3:0] ia, input logic [7:0] ix, input logic [7:0] d,
        input logic [7:0] ea, input logic [7:0] ed);
        int n;
        h.wr(1'b0, ia, ix);
        h.wr(1'b0, ia + 4'h1, d);
        h.idle();
        for (n = 0; n < 8 && crtc_wr !== 1'b1; n++)
            @(negedge mclk);
        // a missing strobe counts once and lets the run reach its verdict
        if (n == 8)
            chk("strobe", 8'h00, 8'h01);
        else
        begin
            chk("crtc_addr", {3'h0, crtc_addr}, ea);
            chk("crtc_wdata", crtc_wdata, ed);
        end
    endtask
    task automatic put(input logic mono, input logic [3:0] a, input logic [7:0] d);
        h.wr(mono, a, d);
        h.idle();
        repeat (3) @(negedge mclk);
    endtask
    task automatic mode_case(input logic mono, input logic [7:0] d);
        put(mono, vmr_pkg::OFS_MODE, d);
        chk("mode_out", mode_out, d);
        chk("text80", {7'h0, text80}, {7'h0, d[0]});
        chk("graphics", {7'h0, graphics}, {7'h0, d[1]});
        chk("text_video_en", {7'h0, text_video_en}, {7'h0, d[3]});
        chk("bitmap_en", {7'h0, bitmap_en}, {7'h0, d[7]});
        chk("emul_mono", {7'h0, emul_mono}, {7'h0, mono});
    endtask
    task automatic pix_case(input logic [7:0] m, input logic [3:0] b, input logic f,
        input logic [3:0] e);
        put(1'b0, vmr_pkg::OFS_MODE, m);
        bmp_index = b;
        txt_fg = f;
        repeat (3) @(negedge mclk);
        chk("pix_out", {4'h0, pix_out}, {4'h0, e});
    endtask
    initial
    begin
        for (int i = 0; i < 18; i++)
            tbl_value[i] = 8'h40 + 8'(i);
        repeat (6) @(negedge mclk);
        rst = 1'b0;
        chk("color reset", color_out, 8'h8a);
        chk("run reset", {7'h0, text_run}, 8'h00);
        ctl_case(vmr_pkg::OFS_CIDX, 8'he2, 8'h11, 8'h02, 8'h42);
        ctl_case(vmr_pkg::OFS_CIDX, 8'h03, 8'h77, 8'h03, 8'h77);
        ctl_case(vmr_pkg::OFS_CIDX, 8'h0c, 8'h44, 8'h0c, 8'h44);
        ctl_case(vmr_pkg::OFS_CIDX, 8'h11, 8'h21, 8'h11, 8'h21);
        ctl_case(vmr_pkg::OFS_DIDX, 8'h02, 8'h11, 8'h02, 8'h11);
        mode_case(1'b0, 8'h1b);
        mode_case(1'b1, 8'h88);
        h.sync_ctl(4);
        // run flag shows two edges after the clearing write
        repeat (3) @(negedge mclk);
        chk("text_run", {7'h0, text_run}, 8'h01);
        put(1'b0, vmr_pkg::OFS_COLOR, 8'hb5);
        chk("run held", {7'h0, text_run}, 8'h01);
        chk("lut_index", {4'h0, lut_index}, 8'h05);
        put(1'b0, 4'h8, 8'hff);
        chk("unmapped", color_out, 8'hb5);
        pix_case(8'hc8, 4'h7, 1'b1, 4'h3);
        pix_case(8'hc8, 4'h5, 1'b1, 4'h5);
        pix_case(8'h88, 4'h6, 1'b0, 4'h6);
        pix_case(8'h88, 4'h6, 1'b1, 4'h3);
        pixel_red_select = 1'b1;
        pix_case(8'h0a, 4'h0, 1'b0, 4'hd);
        pixel_red_select = 1'b0;
        pix_case(8'h0a, 4'h0, 1'b0, 4'h5);
        lut_program = 1'b1;
        put(1'b0, vmr_pkg::OFS_MODE, 8'h00);
        chk("lut_valid", {7'h0, lut_index_valid}, 8'h01);
        put(1'b0, vmr_pkg::OFS_MODE, 8'h40);
        chk("lut_valid off", {7'h0, lut_index_valid}, 8'h00);
        lut_program = 1'b0;
        stop_test();
    end
endmodule
